// ===== verilog/dbu_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the debug serial unit
package dbu_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] OFS_IRQ_DISABLE = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK_VIEW = 8'h10;
	localparam logic [7:0] OFS_UNIT_STATUS = 8'h14;
	localparam logic [7:0] OFS_RX_HOLDING = 8'h18;
	localparam logic [7:0] OFS_TX_HOLDING = 8'h1C;
	localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h20;

	// Control command bit positions
	localparam int CTL_RX_RESET = 2;
	localparam int CTL_TX_RESET = 3;
	localparam int CTL_RX_ON = 4;
	localparam int CTL_RX_OFF = 5;
	localparam int CTL_TX_ON = 6;
	localparam int CTL_TX_OFF = 7;
	localparam int CTL_ERROR_FLAGS_CLEAR = 8;

	// Status and mask bit positions
	localparam int ST_RX_CHAR_READY = 0;
	localparam int ST_TX_HOLD_FREE = 1;
	localparam int ST_RX_DMA_END = 3;
	localparam int ST_TX_DMA_END = 4;
	localparam int ST_OVERRUN = 5;
	localparam int ST_FRAMING = 6;
	localparam int ST_PARITY = 7;
	localparam int ST_TX_IDLE = 9;
	localparam int ST_TX_DMA_BUF_EMPTY = 11;
	localparam int ST_RX_DMA_BUF_FULL = 12;
	localparam int ST_DCC_WRITE = 30;
	localparam int ST_DCC_READ = 31;
	localparam logic [31:0] ST_IMPLEMENTED = 32'hC0001AFB;

	// Reset values
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam logic [15:0] DIVISOR_RESET = 16'h0000;
	localparam logic [8:0] MODE_RESET = 9'h000;
	localparam logic [11:0] MODE_FIELD_MASK = 12'hCE0;

	// Baud generator oversampling
	localparam int BAUD_OVERSAMPLE_SHIFT = 4;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Peripheral DMA and debug channel levels
	typedef struct packed {
		logic dcc_read_status;
		logic dcc_write_status;
		logic rx_dma_buffer_full;
		logic tx_dma_buffer_empty;
		logic tx_dma_end;
		logic rx_dma_end;
	} dbu_side_t;

	// Character handed over by the receive framing logic
	typedef struct packed {
		logic valid;
		logic framing_err;
		logic parity_err;
		logic [7:0] received_char;
	} dbu_rx_char_t;
endpackage : dbu_pkg

// ===== verilog/dbu_top.sv
// Debug serial unit: register slave, status flags, holding registers, baud generator
// How it works
// (R1) Mask bits read one when source enabled
// (R2) Receive ready sets on character, clears read/disable
// (R3) Transmit free low while character waits/disabled
// (R4) Transmitter idle only when fully drained, enabled
// (R5) Overrun, framing, parity errors are sticky
// (R6) DMA end flags mirror channel signals
// (R7) DMA buffer flags mirror channel signals
// (R8) Top status bits mirror core channel flags
// (R9) Receive holding shows last character, upper zero
// (R10) Software writes transmit only when free
// (R11) Divisor: zero off, one direct, else sixteen-times
// (R12) Error clear command resets three error flags
// (R13) Enable sets mask bits, disable clears them
// (R14) Interrupt while any unmasked status flag high
`timescale 1ns/1ps
module dbu_top #(
	parameter int DIV_W = 16
) (
	input wire logic clk_sys, // 250 MHz master clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire dbu_pkg::dbu_rx_char_t rx_in, // Character from receive framing
	input wire logic tx_shift_busy, // Transmit shifter is sending
	input wire dbu_pkg::dbu_side_t side_in, // DMA and debug channel levels
	output logic [7:0] char_to_send, // Character for the shifter
	output logic tx_load, // One-cycle load of the shifter
	output logic rx_enable, // Receive framing enabled
	output logic tx_enable, // Transmit framing enabled
	output logic rx_abort, // Pulse: abort reception
	output logic tx_abort, // Pulse: abort transmission
	output logic [8:0] mode_bits, // Parity and channel mode to framing
	output logic baud_tick, // Baud rate clock enable
	output logic irq // Level interrupt
);
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q, wmask_q, rdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] mask_q;
	logic rx_en_q, tx_en_q, rx_abort_q, tx_abort_q;
	logic rx_ready_q, ovr_q, frame_q, par_q;
	logic [7:0] rx_char_q, tx_hold_q, tx_out_q;
	logic tx_full_q, tx_load_q;
	dbu_pkg::dbu_side_t side_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W+dbu_pkg::BAUD_OVERSAMPLE_SHIFT-1:0] baud_cnt_q;
	logic baud_tick_q, irq_q;
	logic [8:0] mode_q;
	logic [31:0] status_w, rd_w;
	logic wr_fire, rd_fire, rd_ok, wr_ok, rhr_read;
	logic [31:0] cmd_w;
	logic ctl_wr;

	// Byte strobes widened to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strb_mask

	// Address map check shared by both channels
	function automatic logic is_mapped(input logic [7:0] a, input logic wr);
		case (a)
			dbu_pkg::OFS_CONTROL, dbu_pkg::OFS_IRQ_ENABLE, dbu_pkg::OFS_IRQ_DISABLE,
			dbu_pkg::OFS_TX_HOLDING: is_mapped = wr;
			dbu_pkg::OFS_IRQ_MASK_VIEW, dbu_pkg::OFS_UNIT_STATUS,
			dbu_pkg::OFS_RX_HOLDING: is_mapped = !wr;
			dbu_pkg::OFS_MODE, dbu_pkg::OFS_BAUD_DIVISOR: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// Write proceeds once both halves are held and no response is pending
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ok = is_mapped(waddr_q, 1'b1);
	assign cmd_w = wdata_q & wmask_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_ok = is_mapped(s_axi_araddr, 1'b0);
	assign rhr_read = rd_fire && (s_axi_araddr == dbu_pkg::OFS_RX_HOLDING);
	assign ctl_wr = wr_fire && waddr_q == dbu_pkg::OFS_CONTROL;

	// Write channels, taken in either order
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= dbu_pkg::RESP_OKAY;
			waddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wmask_q <= 32'h00000000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				waddr_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wmask_q <= strb_mask(s_axi_wstrb);
			end
			if (wr_fire)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? dbu_pkg::RESP_OKAY : dbu_pkg::RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Status word built from flag flops; unimplemented bits read zero
	always_comb
	begin
		status_w = 32'h00000000;
		status_w[dbu_pkg::ST_RX_CHAR_READY] = rx_ready_q;
		status_w[dbu_pkg::ST_TX_HOLD_FREE] = tx_en_q && !tx_full_q; // R3
		status_w[dbu_pkg::ST_RX_DMA_END] = side_q.rx_dma_end; // R6
		status_w[dbu_pkg::ST_TX_DMA_END] = side_q.tx_dma_end; // R6
		status_w[dbu_pkg::ST_OVERRUN] = ovr_q;
		status_w[dbu_pkg::ST_FRAMING] = frame_q;
		status_w[dbu_pkg::ST_PARITY] = par_q;
		status_w[dbu_pkg::ST_TX_IDLE] = tx_en_q && !tx_full_q && !tx_load_q && !tx_shift_busy; // R4
		status_w[dbu_pkg::ST_TX_DMA_BUF_EMPTY] = side_q.tx_dma_buffer_empty; // R7
		status_w[dbu_pkg::ST_RX_DMA_BUF_FULL] = side_q.rx_dma_buffer_full; // R7
		status_w[dbu_pkg::ST_DCC_WRITE] = side_q.dcc_write_status; // R8
		status_w[dbu_pkg::ST_DCC_READ] = side_q.dcc_read_status; // R8
	end

	// Read data selection
	always_comb
	begin
		case (s_axi_araddr)
			dbu_pkg::OFS_MODE: rd_w = {16'h0000, mode_q[8:7], 2'h0, mode_q[6:4], 9'h000};
			dbu_pkg::OFS_IRQ_MASK_VIEW: rd_w = mask_q; // R1
			dbu_pkg::OFS_UNIT_STATUS: rd_w = status_w;
			dbu_pkg::OFS_RX_HOLDING: rd_w = {24'h000000, rx_char_q}; // R9
			dbu_pkg::OFS_BAUD_DIVISOR: rd_w = {{(32-DIV_W){1'b0}}, div_q};
			default: rd_w = 32'h00000000;
		endcase
	end

	// Read channel, one outstanding read, answer one cycle after the address
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= dbu_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_w;
			rresp_q <= rd_ok ? dbu_pkg::RESP_OKAY : dbu_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Interrupt mask: enable sets, disable clears, zeros leave alone
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			mask_q <= dbu_pkg::MASK_RESET;
		else if (wr_fire && waddr_q == dbu_pkg::OFS_IRQ_ENABLE)
			mask_q <= mask_q | (cmd_w & dbu_pkg::ST_IMPLEMENTED); // R13
		else if (wr_fire && waddr_q == dbu_pkg::OFS_IRQ_DISABLE)
			mask_q <= mask_q & ~cmd_w; // R13
	end

	// Enable state; the off command wins over the on command
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
			rx_abort_q <= 1'b0;
			tx_abort_q <= 1'b0;
		end
		else
		begin
			rx_abort_q <= wr_fire && waddr_q == dbu_pkg::OFS_CONTROL && cmd_w[dbu_pkg::CTL_RX_RESET];
			tx_abort_q <= wr_fire && waddr_q == dbu_pkg::OFS_CONTROL && cmd_w[dbu_pkg::CTL_TX_RESET];
			if (wr_fire && waddr_q == dbu_pkg::OFS_CONTROL)
			begin
				if (cmd_w[dbu_pkg::CTL_RX_OFF] || cmd_w[dbu_pkg::CTL_RX_RESET])
					rx_en_q <= 1'b0;
				else if (cmd_w[dbu_pkg::CTL_RX_ON])
					rx_en_q <= 1'b1;
				if (cmd_w[dbu_pkg::CTL_TX_OFF] || cmd_w[dbu_pkg::CTL_TX_RESET])
					tx_en_q <= 1'b0;
				else if (cmd_w[dbu_pkg::CTL_TX_ON])
					tx_en_q <= 1'b1;
			end
		end
	end

	// Receive holding and ready flag; a new character wins over a read
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rx_ready_q <= 1'b0;
			rx_char_q <= 8'h00;
		end
		else if (!rx_en_q)
			rx_ready_q <= 1'b0; // R2
		else if (rx_in.valid)
		begin
			rx_ready_q <= 1'b1; // R2
			rx_char_q <= rx_in.received_char; // R9
		end
		else if (rhr_read)
			rx_ready_q <= 1'b0; // R2
	end

	// Sticky errors; an error in the clearing cycle survives the clear
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ovr_q <= 1'b0;
			frame_q <= 1'b0;
			par_q <= 1'b0;
		end
		else
		begin
			if (wr_fire && waddr_q == dbu_pkg::OFS_CONTROL && cmd_w[dbu_pkg::CTL_ERROR_FLAGS_CLEAR])
			begin
				ovr_q <= 1'b0; // R12
				frame_q <= 1'b0; // R12
				par_q <= 1'b0; // R12
			end
			if (rx_en_q && rx_in.valid)
			begin
				if (rx_ready_q && !rhr_read)
					ovr_q <= 1'b1; // R5
				if (rx_in.framing_err)
					frame_q <= 1'b1; // R5
				if (rx_in.parity_err)
					par_q <= 1'b1; // R5
			end
		end
	end

	// Transmit holding; writes while disabled are dropped, a pending one still drains
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			tx_full_q <= 1'b0;
			tx_hold_q <= 8'h00;
			tx_out_q <= 8'h00;
			tx_load_q <= 1'b0;
		end
		else
		begin
			tx_load_q <= 1'b0;
			if (tx_abort_q)
				tx_full_q <= 1'b0;
			else if (tx_full_q && !tx_shift_busy && !tx_load_q)
			begin
				tx_full_q <= 1'b0; // R3
				tx_load_q <= 1'b1;
				tx_out_q <= tx_hold_q;
			end
			// A write when not free overwrites the waiting character
			if (wr_fire && waddr_q == dbu_pkg::OFS_TX_HOLDING && tx_en_q)
			begin
				tx_full_q <= 1'b1; // R10
				tx_hold_q <= (wdata_q[7:0] & wmask_q[7:0]) | (tx_hold_q & ~wmask_q[7:0]);
			end
		end
	end

	// Mode and divisor registers, byte lanes honoured
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			div_q <= DIV_W'(dbu_pkg::DIVISOR_RESET);
			mode_q <= dbu_pkg::MODE_RESET;
		end
		else if (wr_fire && waddr_q == dbu_pkg::OFS_BAUD_DIVISOR)
			div_q <= (wdata_q[DIV_W-1:0] & wmask_q[DIV_W-1:0]) | (div_q & ~wmask_q[DIV_W-1:0]);
		else if (wr_fire && waddr_q == dbu_pkg::OFS_MODE && wmask_q[8])
			mode_q <= {wdata_q[15:14], wdata_q[11:9], 4'h0};
	end

	// Baud generator: divided by sixteen times a divisor above one; zero stops it, one ticks every cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			baud_cnt_q <= '0;
			baud_tick_q <= 1'b0;
		end
		else if (div_q == '0)
		begin
			baud_cnt_q <= '0;
			baud_tick_q <= 1'b0; // R11
		end
		else if (div_q == DIV_W'(1))
			baud_tick_q <= 1'b1; // R11
		else if (baud_cnt_q == '0)
		begin
			baud_cnt_q <= {div_q, 4'h0} - 1'b1; // R11
			baud_tick_q <= 1'b1;
		end
		else
		begin
			baud_cnt_q <= baud_cnt_q - 1'b1;
			baud_tick_q <= 1'b0;
		end
	end

	// Mirrored levels and the interrupt, one flop behind their sources
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			side_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			side_q <= side_in; // R6 R7 R8
			irq_q <= |(status_w & mask_q); // R14
		end
	end

	assign char_to_send = tx_out_q;
	assign tx_load = tx_load_q;
	assign rx_enable = rx_en_q;
	assign tx_enable = tx_en_q;
	assign rx_abort = rx_abort_q;
	assign tx_abort = tx_abort_q;
	assign mode_bits = mode_q;
	assign baud_tick = baud_tick_q;
	assign irq = irq_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence ier_write_s;
		wr_fire && waddr_q == dbu_pkg::OFS_IRQ_ENABLE && cmd_w[0];
	endsequence

	sequence idr_write_s;
		wr_fire && waddr_q == dbu_pkg::OFS_IRQ_DISABLE && cmd_w[1];
	endsequence

	sequence mask_read_s;
		rd_fire && s_axi_araddr == dbu_pkg::OFS_IRQ_MASK_VIEW;
	endsequence

	sequence rx_take_s;
		rx_en_q && rx_in.valid;
	endsequence

	sequence thr_write_s;
		wr_fire && waddr_q == dbu_pkg::OFS_TX_HOLDING && tx_en_q;
	endsequence

	// Clear with no character arriving, since an arriving error wins
	sequence err_clear_s;
		ctl_wr && cmd_w[dbu_pkg::CTL_ERROR_FLAGS_CLEAR] && !rx_in.valid;
	endsequence

	// A tick with divisor two, then the divisor still two one cycle on
	sequence tick_two_s;
		div_q == DIV_W'(2) && baud_tick_q ##1 div_q == DIV_W'(2);
	endsequence

	mask_set_a: assert property (ier_write_s |=> mask_q[0]) // R13
		else $error("mask bit not set by enable write");
	mask_clear_a: assert property (idr_write_s |=> !mask_q[1]) // R13
		else $error("mask bit not cleared by disable write");
	mask_view_a: assert property (mask_read_s |=> s_axi_rdata == $past(mask_q)) // R1
		else $error("mask view differs from mask");
	rx_set_a: assert property (rx_take_s |=> rx_ready_q) // R2
		else $error("ready flag not set by character");
	rx_hold_a: assert property (rx_take_s |=> rx_char_q == $past(rx_in.received_char)) // R9
		else $error("received character not held");
	rx_clear_a: assert property (rhr_read && !rx_in.valid |=> !status_w[0]) // R2
		else $error("ready flag survived holding read");
	tx_wait_a: assert property (thr_write_s |=> !status_w[dbu_pkg::ST_TX_HOLD_FREE]) // R3
		else $error("transmit free while character waits");
	tx_idle_a: assert property (!tx_en_q || tx_shift_busy |-> !status_w[dbu_pkg::ST_TX_IDLE]) // R4
		else $error("idle flag high while busy or disabled");
	err_sticky_a: assert property (ovr_q && !ctl_wr |=> ovr_q) // R5
		else $error("overrun flag dropped without clear");
	err_clear_a: assert property (err_clear_s |=> !ovr_q && !frame_q && !par_q) // R12
		else $error("error flags not cleared");
	dma_mirror_a: assert property (##1 side_q == $past(side_in)) // R6 R7 R8
		else $error("mirrored level lags more than one cycle");
	baud_off_a: assert property (div_q == '0 [*2] |-> !baud_tick_q) // R11
		else $error("baud tick with divisor zero");
	baud_two_a: assert property (tick_two_s |-> !baud_tick_q [*8]) // R11
		else $error("baud tick too early");
	irq_level_a: assert property (|(status_w & mask_q) |=> irq_q) // R14
		else $error("interrupt missing for unmasked flag");
	irq_quiet_a: assert property (!(|(status_w & mask_q)) |=> !irq_q) // R14
		else $error("interrupt with no unmasked flag");
endmodule : dbu_top

// ===== bench/dbu_peer.sv
// Serial peer model: receive framing source and transmit shifter timing
`timescale 1ns/1ps
module dbu_peer #(
	parameter int BUSY_LEN = 12
) (
	input wire logic clk_sys, // Master clock
	input wire logic sys_rst, // Sync reset, active high
	input wire dbu_pkg::dbu_rx_char_t rx_req, // Character the bench wants delivered
	input wire logic rx_enable, // Framing on
	input wire logic tx_load, // Shifter load pulse
	input wire logic [7:0] char_to_send, // Loaded character
	input wire logic tx_abort, // Abort the character on the line
	output dbu_pkg::dbu_rx_char_t rx_in, // Delivered character
	output logic tx_shift_busy, // Shifter sending
	output logic [7:0] sent_char // Last character taken by the shifter
);
	int cnt_q;

	// Nothing arrives while framing is off; idle data flips so a stale byte never passes
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			rx_in <= '0;
		else if (rx_req.valid && rx_enable)
			rx_in <= rx_req;
		else
			rx_in <= {3'h0, ~rx_in.received_char};
	end

	// Shifter stays busy for a whole character after each load
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || tx_abort)
			cnt_q <= 0;
		else if (tx_load)
			cnt_q <= BUSY_LEN;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
		if (tx_load)
			sent_char <= char_to_send;
	end

	assign tx_shift_busy = cnt_q > 0;
endmodule : dbu_peer

// ===== bench/tb.sv
// Self-checking bench for the debug serial unit
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] r;
	} dbu_row_t;
	int errors = 0;
	int comparisons = 0;
	int k;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
	logic awready, wready, bvalid, arready, rvalid;
	logic tx_shift_busy, tx_load, rx_enable, tx_enable, tx_abort, baud_tick, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [7:0] char_to_send, sent_char;
	logic [8:0] mode_bits;
	dbu_pkg::dbu_rx_char_t rx_req = '0;
	dbu_pkg::dbu_rx_char_t rx_in;
	dbu_pkg::dbu_side_t side_in = '0;
	// Reset view of every offset but 0x08 and 0x0C, unmapped and write-only among them
	dbu_row_t rows [8] = '{'{8'h10, 32'h0, 2'h0}, '{8'h14, 32'h0, 2'h0},
		'{8'h18, 32'h0, 2'h0}, '{8'h20, 32'h0, 2'h0}, '{8'h04, 32'h0, 2'h0},
		'{8'h1C, 32'h0, 2'h2}, '{8'h24, 32'h0, 2'h2}, '{8'h00, 32'h0, 2'h2}};

	dbu_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_in(rx_in), .tx_shift_busy(tx_shift_busy),
		.side_in(side_in), .char_to_send(char_to_send), .tx_load(tx_load),
		.rx_enable(rx_enable), .tx_enable(tx_enable), .rx_abort(), .tx_abort(tx_abort),
		.mode_bits(mode_bits), .baud_tick(baud_tick), .irq(irq));

	dbu_peer peer (.clk_sys(clk_sys), .sys_rst(sys_rst), .rx_req(rx_req),
		.rx_enable(rx_enable), .tx_load(tx_load), .char_to_send(char_to_send),
		.tx_abort(tx_abort), .rx_in(rx_in), .tx_shift_busy(tx_shift_busy),
		.sent_char(sent_char));

	// 250 MHz master clock
	always #2 clk_sys = ~clk_sys;

	task automatic tally_and_finish;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic reset_dut;
		sys_rst <= 1'h1;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
	endtask : reset_dut

	// Both write halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'h0;
		w = 1'h0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(aw && w))
		begin
			@(posedge clk_sys);
			if (!aw && awready)
				awvalid <= 1'h0;
			if (!w && wready)
				wvalid <= 1'h0;
			aw |= awready;
			w |= wready;
		end
		do
			@(posedge clk_sys);
		while (!bvalid);
		rs = bresp;
	endtask : wr

	task automatic w1(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, r);
	endtask : w1

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'h1;
		do
			@(posedge clk_sys);
		while (!arready);
		arvalid <= 1'h0;
		do
			@(posedge clk_sys);
		while (!rvalid);
		v = rdata;
		rs = rresp;
	endtask : rd

	task automatic stat(input logic [31:0] m);
		rd(8'h14, d, r);
		d = d & m;
	endtask : stat

	task automatic send(input logic [7:0] c, input logic f, input logic p);
		rx_req <= {1'h1, f, p, c};
		@(posedge clk_sys);
		rx_req.valid <= 1'h0;
		@(posedge clk_sys);
	endtask : send

	// Software only writes once the hold register is free
	task automatic wtx(input logic [7:0] c);
		do
			stat(32'h2);
		while (d !== 32'h2);
		w1(8'h1C, {24'h0, c});
	endtask : wtx

	task automatic cnt(input int n, output int t);
		t = 0;
		repeat (n)
		begin
			@(posedge clk_sys);
			t += baud_tick;
		end
	endtask : cnt

	task automatic row_loop;
		for (int i = 0; i < 8; i++)
		begin
			rd(rows[i].a, d, r);
			`CHK({d, r}, {rows[i].d, rows[i].r})
		end
	endtask : row_loop

	// Hang guard well beyond the expected run
	initial
	begin
		repeat (8000) @(posedge clk_sys);
		errors++;
		tally_and_finish();
	end

	initial
	begin
		reset_dut();
		row_loop();
		// Mirrored levels, mask set and clear, interrupt level
		side_in <= '1;
		repeat (3) @(posedge clk_sys);
		stat(32'hFFFFFFFF);
		`CHK(d, 32'hC0001818)
		w1(8'h08, 32'hFFFFFFFF);
		rd(8'h10, d, r);
		`CHK(d, dbu_pkg::ST_IMPLEMENTED)
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'h1)
		w1(8'h0C, 32'h3FFFFFFF);
		rd(8'h10, d, r);
		`CHK(d, 32'hC0000000)
		w1(8'h0C, 32'hC0000000);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'h0)
		side_in <= '0;
		// Mode fields at their own positions and on the framing outputs
		w1(8'h04, 32'h0000CE00);
		rd(8'h04, d, r);
		`CHK(d, 32'h0000CE00)
		`CHK(mode_bits, 9'h1F0)
		// Baud period for divisor 2, then the direct and off settings
		w1(8'h20, 32'h12340002);
		rd(8'h20, d, r);
		`CHK(d, 32'h00000002)
		do
			@(posedge clk_sys);
		while (!baud_tick);
		cnt(31, k);
		`CHK(k, 0)
		cnt(1, k);
		`CHK(k, 1)
		w1(8'h20, 32'h1);
		cnt(8, k);
		`CHK(k, 8)
		w1(8'h20, 32'h0);
		cnt(64, k);
		`CHK(k, 0)
		// Receive, overrun and error flags, clear command, receiver off
		w1(8'h00, 32'h10);
		send(8'hA5, 1'h0, 1'h0);
		stat(32'h1);
		`CHK(d, 32'h1)
		rd(8'h18, d, r);
		`CHK(d, 32'h000000A5)
		stat(32'h1);
		`CHK(d, 32'h0)
		send(8'h11, 1'h0, 1'h0);
		send(8'h22, 1'h1, 1'h1);
		w1(8'h08, 32'h20);
		stat(32'hE1);
		`CHK(d, 32'hE1)
		`CHK(irq, 1'h1)
		w1(8'h00, 32'h100);
		stat(32'hE1);
		`CHK(d, 32'h1)
		`CHK(irq, 1'h0)
		w1(8'h00, 32'h20);
		stat(32'h1);
		`CHK(d, 32'h0)
		// Transmit hand-off, waiting character, idle flag, transmitter off
		w1(8'h00, 32'h40);
		`CHK(tx_enable, 1'h1)
		stat(32'h202);
		`CHK(d, 32'h202)
		wtx(8'h3C);
		stat(32'h200);
		`CHK(d, 32'h0)
		wtx(8'hC3);
		stat(32'h202);
		`CHK(d, 32'h0)
		`CHK(sent_char, 8'h3C)
		repeat (40) @(posedge clk_sys);
		stat(32'h202);
		`CHK(d, 32'h202)
		`CHK(sent_char, 8'hC3)
		w1(8'h00, 32'h80);
		`CHK(tx_enable, 1'h0)
		stat(32'h202);
		`CHK(d, 32'h0)
		// Second reset in mid-run restores every reset value
		w1(8'h08, 32'hFFFFFFFF);
		w1(8'h20, 32'h5);
		reset_dut();
		`CHK(irq, 1'h0)
		row_loop();
		tally_and_finish();
	end
endmodule : tb
